// [src/tbx_crossbar.sv]
// Trigger bus crossbar: register slave, trigger and board pin routing, timebase pin
//
// Contract
// - Per-line direction bits 9..15 of register 58
// - Four-bit source selector per trigger line
// - Codes 0-6 pick internal timing signals
// - Code 7 counter route, 8-11 board pins
// - Subselect bit picks counter output source
// - Three-bit board selector picks trigger line
// - Board code 7: stop or function pin
// - Board pin direction bits 12..15
// - Mode 0: local oscillator, pin undriven
// - Mode 1: drive pin, direct timebase
// - Mode 2: pin input is timebase
// - Mode 3: drive pin, buffered timebase
// - Input trigger lines feed internal selectors
// - Trigger lines power up as inputs
// - Function pin seven: active or start
//
// The Avalon-MM slave port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module tbx_crossbar (
   input  wire logic                            core_clk_in,
   input  wire logic                            reset_n_in,
   // Avalon-MM slave
   input  wire logic [tbx_pkg::TBX_ADDR_W-1:0]  avs_address_in,
   input  wire logic                            avs_read_in,
   input  wire logic                            avs_write_in,
   input  wire logic [31:0]                     avs_writedata_in,
   input  wire logic [3:0]                      avs_byteenable_in,
   output logic      [31:0]                     avs_readdata_out,
   output logic                                 avs_waitrequest_out,
   output logic      [1:0]                      avs_response_out,
   // Internal timing sources
   input  wire tbx_pkg::tbx_src_s               src_in,
   // Trigger lines
   input  wire logic [6:0]                      sync_trigger_line_in,
   output logic      [6:0]                      sync_trigger_line_out,
   output logic      [6:0]                      sync_trigger_line_oe_out,
   // Board side pins
   input  wire logic [3:0]                      board_side_pin_in,
   output logic      [3:0]                      board_side_pin_out,
   output logic      [3:0]                      board_side_pin_oe_out,
   // Shared oscillator pin
   input  wire logic                            shared_osc_pin_in,
   output logic                                 shared_osc_pin_out,
   output logic                                 shared_osc_pin_oe_out,
   input  wire logic                            local_oscillator_input_in,
   // Received trigger lines towards internal selectors
   output logic      [6:0]                      trig_to_selectors_out,
   // Timebase selection result
   output logic                                 timebase_from_pin_out,
   output logic                                 timebase_buffered_out
);
   // Configuration registers
   logic [15:0] dir_mode_r;     // Trigger dirs and timebase mode
   logic [15:0] trig_low_r;     // Selectors lines 0..3
   logic [15:0] trig_high_r;    // Selectors lines 4..6 and subselect
   logic [15:0] board_r;        // Board selectors and dirs
   tbx_pkg::tbx_state_e state_r;
   tbx_pkg::tbx_state_e state_nxt;
   logic [31:0] rdata_nxt;
   logic [1:0]  resp_nxt;

   // Synchronised pins
   logic [6:0] trig_sync;
   logic [3:0] brd_sync;
   logic       cnt_pin_sync;
   logic       osc_sync;       // Local oscillator level after two flops

   tbx_sync #(.WIDTH(13)) u_sync (
      .core_clk_in (core_clk_in),
      .reset_n_in  (reset_n_in),
      .async_in    ({local_oscillator_input_in, src_in.counter0_output_pin,
                     board_side_pin_in, sync_trigger_line_in}),
      .sync_out    ({osc_sync, cnt_pin_sync, brd_sync, trig_sync})
   );

   // Address decode
   wire [7:0] word_idx = avs_address_in[tbx_pkg::TBX_ADDR_W-1:2];
   wire       aligned  = (avs_address_in[1:0] == 2'h0);
   wire       hit_dir  = aligned && (word_idx == tbx_pkg::TBX_IDX_DIR_MODE);
   wire       hit_tlo  = aligned && (word_idx == tbx_pkg::TBX_IDX_TRIG_LOW);
   wire       hit_thi  = aligned && (word_idx == tbx_pkg::TBX_IDX_TRIG_HIGH);
   wire       hit_brd  = aligned && (word_idx == tbx_pkg::TBX_IDX_BOARD);
   wire       hit_pin  = aligned && (word_idx == tbx_pkg::TBX_IDX_PIN_STATE);
   wire       hit_shd  = aligned && (word_idx == tbx_pkg::TBX_IDX_SHADOW);
   wire       mapped   = hit_dir | hit_tlo | hit_thi | hit_brd | hit_pin | hit_shd;
   // Write-only registers read as zero at their own offsets
   wire       rd_zero  = hit_dir | hit_tlo | hit_thi | hit_brd;
   wire       req      = avs_read_in | avs_write_in;
   wire       wr_fire  = avs_write_in && (state_r == tbx_pkg::TBX_ST_IDLE);

   // Byte-lane merge of a 16-bit register
   function automatic logic [15:0] merge16(input logic [15:0] old,
                                           input logic [31:0] wd,
                                           input logic [3:0]  be);
      merge16 = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
   endfunction : merge16

   // Pin state word for software
   wire [31:0] pin_word = {7'h00, timebase_from_pin_out, shared_osc_pin_oe_out,
                           board_side_pin_oe_out, sync_trigger_line_oe_out,
                           1'b0, brd_sync, trig_sync};
   wire [31:0] shd_word = {dir_mode_r, board_r};

   // Read mux; unmapped answers decode error
   always_comb begin
      rdata_nxt = 32'h0000_0000;
      resp_nxt  = 2'h0;
      if (!mapped) begin
         resp_nxt = 2'h3;                // Decode error
      end else if (avs_read_in && hit_pin) begin
         rdata_nxt = pin_word;
      end else if (avs_read_in && hit_shd) begin
         rdata_nxt = shd_word;
      end else if (avs_read_in && rd_zero) begin
         rdata_nxt = 32'h0000_0000;
      end
   end

   // Two-phase handshake: accept, then drop waitrequest one cycle
   always_comb begin
      case (state_r)
         tbx_pkg::TBX_ST_IDLE: state_nxt = req ? tbx_pkg::TBX_ST_ACK : tbx_pkg::TBX_ST_IDLE;
         tbx_pkg::TBX_ST_ACK:  state_nxt = tbx_pkg::TBX_ST_IDLE;
         default:              state_nxt = tbx_pkg::TBX_ST_IDLE;
      endcase
   end

   // Bus state and answer flops
   always_ff @(posedge core_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         state_r             <= tbx_pkg::TBX_ST_IDLE;
         avs_waitrequest_out <= 1'b1;
         avs_readdata_out    <= 32'h0000_0000;
         avs_response_out    <= 2'h0;
      end else begin
         state_r             <= state_nxt;
         avs_waitrequest_out <= !(req && state_r == tbx_pkg::TBX_ST_IDLE);
         avs_readdata_out    <= rdata_nxt;
         avs_response_out    <= resp_nxt;
      end
   end

   // Register writes; reset leaves every pin an input
   always_ff @(posedge core_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         dir_mode_r  <= tbx_pkg::TBX_RST_REG;
         trig_low_r  <= tbx_pkg::TBX_RST_REG;
         trig_high_r <= tbx_pkg::TBX_RST_REG;
         board_r     <= tbx_pkg::TBX_RST_REG;
      end else if (wr_fire) begin
         if (hit_dir) dir_mode_r  <= merge16(dir_mode_r,  avs_writedata_in, avs_byteenable_in);
         if (hit_tlo) trig_low_r  <= merge16(trig_low_r,  avs_writedata_in, avs_byteenable_in);
         if (hit_thi) trig_high_r <= merge16(trig_high_r, avs_writedata_in, avs_byteenable_in);
         if (hit_brd) board_r     <= merge16(board_r,     avs_writedata_in, avs_byteenable_in);
      end
   end

   // Field extraction
   wire [6:0]  trig_dir = dir_mode_r[tbx_pkg::TBX_TRIG_DIR_LSB +: 7];
   wire [3:0]  brd_dir  = board_r[tbx_pkg::TBX_BRD_DIR_LSB +: 4];
   wire [1:0]  mode_raw = dir_mode_r[tbx_pkg::TBX_MODE_LSB +: 2];
   wire [27:0] tsel_all = {trig_high_r[11:0], trig_low_r};
   wire        subsel   = trig_high_r[tbx_pkg::TBX_SUBSEL_BIT];

   // Counter route: internal output or pin level
   wire cnt_route = subsel ? cnt_pin_sync : src_in.counter0_internal_out;

   // Function pin seven: active flag or start pulse, stretched one cycle
   logic start_d_r;
   always_ff @(posedge core_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) start_d_r <= 1'b0;
      else             start_d_r <= src_in.analog_in_start_pulse;
   end
   wire start_str = src_in.analog_in_start_pulse |
                    (src_in.trigger_stretch_setting & start_d_r);
   wire fpin7     = src_in.start_pin_output_choice ? src_in.acquisition_active
                                                   : start_str;

   // Internal source vector indexed by code 0..7
   wire [7:0] int_src = {cnt_route, src_in.counter_gate, src_in.counter_source_input,
                         src_in.ao_first_start, src_in.ao_update,
                         src_in.gated_convert_clock, src_in.ai_second_start,
                         src_in.ai_first_start};

   // Trigger line selection
   logic [6:0] trig_val;
   genvar t;
   generate
      for (t = 0; t < tbx_pkg::TBX_NUM_TRIG; t++) begin : g_trig
         wire [3:0] sel = tsel_all[t*4 +: 4];
         // Codes above 11 are unused and give a low level
         assign trig_val[t] = (sel <= tbx_pkg::TBX_TSRC_CNT0_ROUTE) ? int_src[sel[2:0]] :
                              (sel <= tbx_pkg::TBX_TSRC_BRD3) ? brd_sync[sel[1:0]] :
                              1'b0;
      end
   endgenerate

   // Board pin selection
   logic [3:0] brd_val;
   genvar b;
   generate
      for (b = 0; b < tbx_pkg::TBX_NUM_BRD; b++) begin : g_brd
         wire [2:0] sel = board_r[b*3 +: 3];
         wire special = (b < 2) ? src_in.analog_in_stop : fpin7;
         assign brd_val[b] = (sel == tbx_pkg::TBX_BSRC_SPECIAL) ? special
                                                                : trig_sync[sel];
      end
   endgenerate

   // Oscillator pin control per mode
   wire osc_drive  = (mode_raw == tbx_pkg::TBX_MODE_DRIVE) ||
                     (mode_raw == tbx_pkg::TBX_MODE_MASTER);
   wire tb_pin     = (mode_raw == tbx_pkg::TBX_MODE_SLAVE);
   wire tb_buffer  = (mode_raw == tbx_pkg::TBX_MODE_MASTER);

   // Pin drive flops; input pins keep enable low
   always_ff @(posedge core_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         sync_trigger_line_out    <= 7'h00;
         sync_trigger_line_oe_out <= 7'h00;
         board_side_pin_out       <= 4'h0;
         board_side_pin_oe_out    <= 4'h0;
         trig_to_selectors_out    <= 7'h00;
         shared_osc_pin_out       <= 1'b0;
         shared_osc_pin_oe_out    <= 1'b0;
         timebase_from_pin_out    <= 1'b0;
         timebase_buffered_out    <= 1'b0;
      end else begin
         sync_trigger_line_out    <= trig_val & trig_dir;
         sync_trigger_line_oe_out <= trig_dir;
         board_side_pin_out       <= brd_val & brd_dir;
         board_side_pin_oe_out    <= brd_dir;
         // Only input lines are offered to the internal selectors
         trig_to_selectors_out    <= trig_sync & ~trig_dir;
         // Local oscillator sampled as a level; three cycles late on the pin
         shared_osc_pin_out       <= osc_drive & osc_sync;
         shared_osc_pin_oe_out    <= osc_drive;
         timebase_from_pin_out    <= tb_pin;
         timebase_buffered_out    <= tb_buffer;
      end
   end
endmodule : tbx_crossbar
`default_nettype wire

// [inc/tbx_pkg.sv]
// Package with register map, field layout and codes for the trigger bus crossbar
package tbx_pkg;
   // Register indices as printed; byte address is four times the index
   localparam logic [7:0] TBX_IDX_DIR_MODE  = 8'h3A;
   localparam logic [7:0] TBX_IDX_TRIG_LOW  = 8'h4F;
   localparam logic [7:0] TBX_IDX_TRIG_HIGH = 8'h50;
   localparam logic [7:0] TBX_IDX_BOARD     = 8'h51;
   // Extra read-only pin state register
   localparam logic [7:0] TBX_IDX_PIN_STATE = 8'h60;
   // Read-back register of the written direction/mode and board settings
   localparam logic [7:0] TBX_IDX_SHADOW    = 8'h61;
   localparam int TBX_ADDR_W   = 10;
   localparam int TBX_NUM_TRIG = 7;
   localparam int TBX_NUM_BRD  = 4;
   // Field positions
   localparam int TBX_MODE_LSB     = 0;
   localparam int TBX_TRIG_DIR_LSB = 9;
   localparam int TBX_TSEL_W       = 4;
   localparam int TBX_SUBSEL_BIT   = 15;
   localparam int TBX_BSEL_W       = 3;
   localparam int TBX_BRD_DIR_LSB  = 12;
   // Reset values: every pin an input, mode 0
   localparam logic [15:0] TBX_RST_REG = 16'h0000;
   // Trigger source codes
   localparam logic [3:0] TBX_TSRC_CNT0_ROUTE = 4'h7;
   localparam logic [3:0] TBX_TSRC_BRD0       = 4'h8;
   localparam logic [3:0] TBX_TSRC_BRD3       = 4'hB;
   localparam logic [2:0] TBX_BSRC_SPECIAL    = 3'h7;
   // Timebase sharing modes
   typedef enum logic [1:0] {
      TBX_MODE_LOCAL  = 2'h0,
      TBX_MODE_DRIVE  = 2'h1,
      TBX_MODE_SLAVE  = 2'h2,
      TBX_MODE_MASTER = 2'h3
   } tbx_mode_e;
   // Internal timing sources and settings for the trigger line and board pin selectors
   typedef struct packed {
      logic ai_first_start;
      logic ai_second_start;
      logic gated_convert_clock;
      logic ao_update;
      logic ao_first_start;
      logic counter_source_input;
      logic counter_gate;
      logic counter0_internal_out;
      logic counter0_output_pin;
      logic analog_in_stop;
      logic analog_in_start_pulse;
      logic acquisition_active;
      logic start_pin_output_choice;
      logic trigger_stretch_setting;
   } tbx_src_s;
   // Bus access phase states
   typedef enum logic [1:0] {
      TBX_ST_IDLE = 2'b01,
      TBX_ST_ACK  = 2'b10
   } tbx_state_e;
endpackage : tbx_pkg

// [src/tbx_sync.sv]
// Two-flop synchroniser bank for pin inputs
`timescale 1ns/1ps
`default_nettype none
module tbx_sync #(
   parameter int WIDTH = 1
) (
   input  wire logic             core_clk_in,
   input  wire logic             reset_n_in,
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] meta_r;   // First stage, read only by second stage

   // Double flop to settle metastability
   always_ff @(posedge core_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         meta_r   <= '0;
         sync_out <= '0;
      end else begin
         meta_r   <= async_in;
         sync_out <= meta_r;
      end
   end
endmodule : tbx_sync
`default_nettype wire

// [sim/tbx_crossbar_assertions.sv]
// Port assertions for the trigger bus crossbar
`timescale 1ns/1ps
`default_nettype none
module tbx_crossbar_checker (
   input wire logic        core_clk_in,
   input wire logic        reset_n_in,
   input wire logic [9:0]  avs_address_in,
   input wire logic        avs_write_in,
   input wire logic [31:0] avs_writedata_in,
   input wire logic        avs_waitrequest_out,
   input wire logic [1:0]  avs_response_out,
   input wire logic [6:0]  sync_trigger_line_out,
   input wire logic [6:0]  sync_trigger_line_oe_out,
   input wire logic [3:0]  board_side_pin_out,
   input wire logic [3:0]  board_side_pin_oe_out,
   input wire logic        shared_osc_pin_out,
   input wire logic        shared_osc_pin_oe_out,
   input wire logic        local_oscillator_input_in,
   input wire logic [6:0]  trig_to_selectors_out,
   input wire logic        timebase_from_pin_out,
   input wire logic        timebase_buffered_out
);
   default clocking cb @(posedge core_clk_in); endclocking
   default disable iff (!reset_n_in);
   wire [7:0] idx_w = avs_address_in[9:2];          // Word index
   wire       al_w  = avs_address_in[1:0] == 2'h0;  // Aligned access
   wire       map_w = al_w && idx_w inside {8'h3A, 8'h4F, 8'h50, 8'h51, 8'h60, 8'h61};
   wire       acc_w = avs_write_in && !avs_waitrequest_out && al_w;  // Write taken
   wire       dm_w  = acc_w && idx_w == 8'h3A;      // Direction and mode write
   wire       bd_w  = acc_w && idx_w == 8'h51;      // Board routing write
   logic [15:0] dm_r, bd_r;                         // Last written settings
   // Byte lanes are not decoded: the bench always writes both low lanes
   always_ff @(posedge core_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         dm_r <= 16'h0000;
         bd_r <= 16'h0000;
      end else begin
         if (dm_w) dm_r <= avs_writedata_in[15:0];
         if (bd_w) bd_r <= avs_writedata_in[15:0];
      end
   end
   // Expected drive, slave and master flags of the timebase mode
   wire [2:0] md_w = {dm_r[0], dm_r[1:0] == 2'h2, dm_r[1:0] == 2'h3};
   decode_resp_a: assert property (!avs_waitrequest_out |->
      avs_response_out == (map_w ? 2'h0 : 2'h3)) else $error("wrong response code");
   dir_follow_a: assert property (dm_w |-> ##[1:3]
      sync_trigger_line_oe_out == dm_r[15:9]) else $error("trigger direction not applied");
   board_dir_a: assert property (bd_w |-> ##[1:3]
      board_side_pin_oe_out == bd_r[15:12]) else $error("board direction not applied");
   mode_follow_a: assert property (dm_w |-> ##[1:3]
      {shared_osc_pin_oe_out, timebase_from_pin_out, timebase_buffered_out} == md_w)
      else $error("timebase mode not applied");
   input_undriven_a: assert property ((sync_trigger_line_out & ~sync_trigger_line_oe_out)
      == 7'h00 && (board_side_pin_out & ~board_side_pin_oe_out) == 4'h0)
      else $error("undriven pin shows a level");
   reset_inputs_a: assert property ($rose(reset_n_in) |->
      sync_trigger_line_oe_out == 7'h00 && board_side_pin_oe_out == 4'h0)
      else $error("pins not inputs after reset");
   sel_mask_a: assert property ((trig_to_selectors_out & sync_trigger_line_oe_out
      & $past(sync_trigger_line_oe_out)) == 7'h00) else $error("driven line reaches selectors");
   slave_nodrive_a: assert property (timebase_from_pin_out |->
      !shared_osc_pin_oe_out) else $error("slave drives the shared pin");
   // Local level crosses two sync flops and the pin flop, so it must stand four samples
   osc_follow_a: assert property (shared_osc_pin_oe_out &&
      $past(shared_osc_pin_oe_out) &&
      $past(local_oscillator_input_in, 3) == local_oscillator_input_in &&
      $past(local_oscillator_input_in, 2) == local_oscillator_input_in &&
      $past(local_oscillator_input_in) == local_oscillator_input_in |->
      shared_osc_pin_out == local_oscillator_input_in) else $error("shared pin not local level");
endmodule : tbx_crossbar_checker
bind tbx_crossbar tbx_crossbar_checker chk_u (.*);
`default_nettype wire

// [sim/tbx_far_model.sv]
// Far side model: other boards on the trigger bus and board logic
`timescale 1ns/1ps
`default_nettype none
module tbx_far_model (
   input  wire logic [6:0] dev_trig_in,     // Device trigger levels
   input  wire logic [6:0] dev_trig_oe_in,  // Device trigger enables
   input  wire logic [6:0] far_trig_in,     // Other boards' levels
   input  wire logic [6:0] far_trig_en_in,  // Other boards driving
   input  wire logic [3:0] dev_brd_in,      // Device board pin levels
   input  wire logic [3:0] dev_brd_oe_in,   // Device board pin enables
   input  wire logic [3:0] far_brd_in,      // Board logic levels
   input  wire logic [3:0] far_brd_en_in,   // Board logic driving
   input  wire logic       dev_osc_in,      // Device shared pin level
   input  wire logic       dev_osc_oe_in,   // Device shared pin enable
   output logic      [6:0] trig_wire_out,   // Resolved trigger lines
   output logic      [3:0] brd_wire_out,    // Resolved board pins
   output logic            osc_wire_out     // Resolved shared pin
);
   // Device first, else the far driver, else the pull-up; contention is not modelled
   assign trig_wire_out = (dev_trig_oe_in & dev_trig_in) | (~dev_trig_oe_in &
      ((far_trig_en_in & far_trig_in) | ~far_trig_en_in));
   assign brd_wire_out = (dev_brd_oe_in & dev_brd_in) | (~dev_brd_oe_in &
      ((far_brd_en_in & far_brd_in) | ~far_brd_en_in));
   // Released shared pin floats high on its pull-up
   assign osc_wire_out = dev_osc_oe_in ? dev_osc_in : 1'b1;
endmodule : tbx_far_model
`default_nettype wire

// [sim/testbench.sv]
// Self-checking bench for the trigger bus crossbar
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin mismatches++; \
$display("[ERR] %0t got %h exp %h", $time, (g), (e)); end end
module testbench;
   logic              core_clk;                     // 125 MHz clock
   logic              reset_n = 1'b0;               // Reset, active low
   logic [9:0]        addr = 10'h000;               // Bus byte address
   logic              rd = 1'b0, wr = 1'b0;         // Bus strobes
   logic [31:0]       wdata = 32'h0, rdata, q;      // Bus data, last read
   logic [3:0]        be = 4'h3;                    // Low lanes only
   logic              wreq, osc_loc = 1'b0, osc_o, osc_oe, osc_w, tb_pin, tb_buf;
   logic [1:0]        resp, rsp;                    // Response, last taken
   tbx_pkg::tbx_src_s src = '0;                     // Internal sources
   logic [6:0]        trig_o, trig_oe, trig_w, sel_o, far_tv = 7'h00, far_te = 7'h00;
   logic [3:0]        brd_o, brd_oe, brd_w, far_bv = 4'h0, far_be = 4'h0, c;
   int                mismatches = 0, tests_run = 0;
   logic [13:0] s7 [4] = '{14'h0010, 14'h0006, 14'h0008, 14'h0004}; // Code 7 cases
   logic [3:0]  e7 [4] = '{4'h3, 4'hC, 4'hC, 4'h0};                 // Their pin levels
   tbx_crossbar dut_u (.core_clk_in(core_clk), .reset_n_in(reset_n), .avs_address_in(addr),
      .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wdata), .avs_byteenable_in(be),
      .avs_readdata_out(rdata), .avs_waitrequest_out(wreq), .avs_response_out(resp),
      .src_in(src), .sync_trigger_line_in(trig_w), .sync_trigger_line_out(trig_o),
      .sync_trigger_line_oe_out(trig_oe), .board_side_pin_in(brd_w), .board_side_pin_out(brd_o),
      .board_side_pin_oe_out(brd_oe), .shared_osc_pin_in(osc_w), .shared_osc_pin_out(osc_o),
      .shared_osc_pin_oe_out(osc_oe), .local_oscillator_input_in(osc_loc),
      .trig_to_selectors_out(sel_o), .timebase_from_pin_out(tb_pin),
      .timebase_buffered_out(tb_buf));
   tbx_far_model far_u (.dev_trig_in(trig_o), .dev_trig_oe_in(trig_oe), .far_trig_in(far_tv),
      .far_trig_en_in(far_te), .dev_brd_in(brd_o), .dev_brd_oe_in(brd_oe), .far_brd_in(far_bv),
      .far_brd_en_in(far_be), .dev_osc_in(osc_o), .dev_osc_oe_in(osc_oe),
      .trig_wire_out(trig_w), .brd_wire_out(brd_w), .osc_wire_out(osc_w));
   initial begin
      core_clk = 1'b0;
      forever #4 core_clk = ~core_clk;
   end
   // One transfer; request held until waitrequest is sampled low
   task automatic bus(input logic w, input logic [9:0] a, input logic [15:0] d);
      int n;
      n = 0;
      @(posedge core_clk);
      addr <= a;
      wr <= w;
      rd <= ~w;
      wdata <= {16'h0000, d};
      do begin
         @(posedge core_clk);
         n++;
      end while (wreq !== 1'b0 && n < 40);
      `CHK(n < 40, 1'b1)
      q = rdata;
      rsp = resp;
      wr <= 1'b0;
      rd <= 1'b0;
   endtask : bus
   // Covers register, two sync stages and output flop
   task automatic settle();
      repeat (5) @(posedge core_clk);
   endtask : settle
   task automatic stop_test();
      $display("comparisons %0d mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : stop_test
   // Hang guard, far beyond the few hundred cycles of the run
   initial begin
      #100000;
      mismatches++;
      stop_test();
   end
   initial begin
      repeat (10) @(posedge core_clk);
      reset_n <= 1'b1;
      `CHK({trig_oe, brd_oe, osc_oe, wreq}, 13'h0001)
      bus(1'b1, 10'h0E8, 16'hFE00);
      for (int k = 0; k < 9; k++) begin
         c = (k > 7) ? 4'h7 : 4'(k);
         bus(1'b1, 10'h13C, {4{c}});
         bus(1'b1, 10'h140, {k == 8, 3'h0, {3{c}}});
         src <= 14'h2000 >> k;
         settle();
         `CHK(trig_o, 7'h7F)
         src <= '0;
         settle();
         `CHK(trig_o, 7'h00)
      end
      $display("test internal sources done");
      far_be <= 4'hF;
      for (int j = 0; j < 4; j++) begin
         c = 4'h8 + 4'(j);
         bus(1'b1, 10'h13C, {4{c}});
         bus(1'b1, 10'h140, {4'h0, {3{c}}});
         far_bv <= 4'h1 << j;
         settle();
         `CHK({trig_o, brd_oe}, 11'h7F0)
         far_bv <= ~(4'h1 << j);
         settle();
         `CHK(trig_o, 7'h00)
      end
      $display("test board to trigger done");
      bus(1'b1, 10'h0E8, 16'h0000);
      far_be <= 4'h0;
      far_te <= 7'h7F;
      for (int j = 0; j < 7; j++) begin
         bus(1'b1, 10'h144, {4'hF, {4{3'(j)}}});
         far_tv <= 7'h01 << j;
         settle();
         `CHK({trig_oe, brd_o, sel_o}, {7'h00, 4'hF, 7'h01 << j})
         far_tv <= ~(7'h01 << j);
         settle();
         `CHK(brd_o, 4'h0)
      end
      $display("test trigger to board done");
      bus(1'b1, 10'h144, 16'hFFFF);
      for (int i = 0; i < 4; i++) begin
         src <= s7[i];
         settle();
         `CHK(brd_o, e7[i])
      end
      // Start pulse of one cycle must stand a second cycle when stretched
      src <= 14'h0009;
      @(posedge core_clk);
      src <= 14'h0001;
      repeat (2) @(posedge core_clk);
      `CHK(brd_o, 4'hC)
      @(posedge core_clk);
      `CHK(brd_o, 4'h0)
      $display("test board code seven done");
      osc_loc <= 1'b1;
      for (int m = 0; m < 4; m++) begin
         bus(1'b1, 10'h0E8, 16'(m));
         settle();
         `CHK({osc_oe,osc_o,osc_w,tb_pin,tb_buf}, {m[0],m[0],1'b1,m==2,m==3})
      end
      // Master mode must follow a low local level too
      osc_loc <= 1'b0;
      settle();
      `CHK({osc_oe, osc_o, osc_w}, 3'b100)
      $display("test timebase modes done");
      bus(1'b0, 10'h184, 16'h0000);
      `CHK({q, rsp}, {32'h0003FFFF, 2'h0})
      bus(1'b0, 10'h0E8, 16'h0000);
      `CHK({q, rsp}, {32'h00000000, 2'h0})
      bus(1'b1, 10'h0E9, 16'h0000);
      `CHK(rsp, 2'h3)
      bus(1'b1, 10'h204, 16'h0000);
      `CHK(rsp, 2'h3)
      bus(1'b0, 10'h184, 16'h0000);
      `CHK(q, 32'h0003FFFF)
      // Lines 0..5 high from far boards, board pins driven low, master mode
      bus(1'b0, 10'h180, 16'h0000);
      `CHK({q, rsp}, {32'h00F8003F, 2'h0})
      $display("test register access done");
      // Reset in mid-run returns every pin to input
      reset_n <= 1'b0;
      repeat (2) @(posedge core_clk);
      reset_n <= 1'b1;
      `CHK({trig_oe, brd_oe, osc_oe, wreq}, 13'h0001)
      bus(1'b0, 10'h184, 16'h0000);
      `CHK(q, 32'h00000000)
      $display("test mid-run reset done");
      stop_test();
   end
endmodule : testbench
`default_nettype wire
